// file: rtl/csc_pkg.sv
// Package for the call / sign-extend / carry-clear execute block
// Assumes a 16-bit core with a byte-wide or word-wide external bus variant
package csc_pkg;
    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_CALL_NEAR_REL = 8'hE8;
    localparam logic [7:0] OPC_CALL_GRP = 8'hFF;
    localparam logic [7:0] OPC_CALL_FAR_DIR = 8'h9A;
    localparam logic [7:0] OPC_SIGN_EXT = 8'h98;
    localparam logic [7:0] OPC_CARRY_CLR = 8'hF8;
    localparam logic [2:0] MODRM_REG_NEAR = 3'h2;
    localparam logic [2:0] MODRM_REG_FAR = 3'h3;
    localparam logic [1:0] MODRM_MOD_REG = 2'h3;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CARRY_FLAG_BIT = 0;
    localparam int ACC_SIGN_BIT = 7;
    localparam logic [7:0] ACC_HIGH_ONES = 8'hFF;
    localparam logic [7:0] ACC_HIGH_ZEROS = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // ------------------------------------------------------------
    // Cycle counts: word-bus variant, then byte-bus variant
    // ------------------------------------------------------------
    localparam logic [5:0] CYC_NEAR_REL_W = 6'd15;
    localparam logic [5:0] CYC_NEAR_REL_B = 6'd19;
    localparam logic [5:0] CYC_NEAR_REG_W = 6'd13;
    localparam logic [5:0] CYC_NEAR_REG_B = 6'd17;
    localparam logic [5:0] CYC_NEAR_MEM_W = 6'd19;
    localparam logic [5:0] CYC_NEAR_MEM_B = 6'd27;
    localparam logic [5:0] CYC_FAR_DIR_W = 6'd23;
    localparam logic [5:0] CYC_FAR_DIR_B = 6'd31;
    localparam logic [5:0] CYC_FAR_MEM_W = 6'd38;
    localparam logic [5:0] CYC_FAR_MEM_B = 6'd54;
    localparam logic [5:0] CYC_SHORT_OP = 6'd2;
    // ------------------------------------------------------------
    // Decoded operation class
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        CSC_OP_NONE = 8'h01,
        CSC_OP_NEAR_REL = 8'h02,
        CSC_OP_NEAR_REG = 8'h04,
        CSC_OP_NEAR_MEM = 8'h08,
        CSC_OP_FAR_DIR = 8'h10,
        CSC_OP_FAR_MEM = 8'h20,
        CSC_OP_SIGN_EXT = 8'h40,
        CSC_OP_CARRY_CLR = 8'h80
    } csc_op_t;
    typedef enum logic [1:0] {
        CSC_ST_IDLE = 2'h1,
        CSC_ST_BUSY = 2'h2
    } csc_state_t;
endpackage

// file: rtl/csc_dec_if.sv
// Interface between the decoder and the execute sequencer
// Assumes both ends share the core clock
interface csc_dec_if;
    import csc_pkg::*;
    csc_op_t op;
    logic [5:0] cycles;
    modport dec (output op, output cycles);
    modport exe (input op, input cycles);
endinterface

// file: rtl/csc_decoder.sv
// Opcode decoder with per-form cycle counts
// Assumes opcode and addressing byte are stable while the request is raised
module csc_decoder
    import csc_pkg::*;
(
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_modrm,
    input wire logic i_byte_bus,
    csc_dec_if.dec dec
);
    import csc_pkg::*;
    // ------------------------------------------------------------
    // Decode and cycle lookup
    // ------------------------------------------------------------
    // Classify opcode, pick count for the bus variant
    always_comb
    begin
        dec.op = CSC_OP_NONE;
        dec.cycles = CYC_SHORT_OP;
        case (i_opcode)
            OPC_CALL_NEAR_REL:
            begin
                dec.op = CSC_OP_NEAR_REL;
                dec.cycles = i_byte_bus ? CYC_NEAR_REL_B : CYC_NEAR_REL_W;
            end
            OPC_CALL_FAR_DIR:
            begin
                dec.op = CSC_OP_FAR_DIR;
                dec.cycles = i_byte_bus ? CYC_FAR_DIR_B : CYC_FAR_DIR_W;
            end
            OPC_CALL_GRP:
            begin
                if (i_modrm[5:3] == MODRM_REG_NEAR)
                begin
                    if (i_modrm[7:6] == MODRM_MOD_REG)
                    begin
                        dec.op = CSC_OP_NEAR_REG;
                        dec.cycles = i_byte_bus ? CYC_NEAR_REG_B : CYC_NEAR_REG_W;
                    end
                    else
                    begin
                        dec.op = CSC_OP_NEAR_MEM;
                        dec.cycles = i_byte_bus ? CYC_NEAR_MEM_B : CYC_NEAR_MEM_W;
                    end
                end
                else if (i_modrm[5:3] == MODRM_REG_FAR && i_modrm[7:6] != MODRM_MOD_REG)
                begin
                    dec.op = CSC_OP_FAR_MEM;
                    dec.cycles = i_byte_bus ? CYC_FAR_MEM_B : CYC_FAR_MEM_W;
                end
            end
            OPC_SIGN_EXT:
            begin
                dec.op = CSC_OP_SIGN_EXT;
                dec.cycles = CYC_SHORT_OP;
            end
            OPC_CARRY_CLR:
            begin
                dec.op = CSC_OP_CARRY_CLR;
                dec.cycles = CYC_SHORT_OP;
            end
            default:
            begin
                dec.op = CSC_OP_NONE;
                dec.cycles = CYC_SHORT_OP;
            end
        endcase
    end
endmodule

// file: rtl/csc_exec.sv
// Execute unit for procedure calls, byte sign extension and carry clear
// Assumes the core supplies operands, pre-instruction stack pointer and stack
// writes are performed by an outside stack unit from the push outputs
// ------------------------------------------------------------
// ------------------------------------------------------------
module csc_exec
    import csc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic i_byte_bus,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_modrm,
    input wire logic [15:0] i_next_instr_offset,
    input wire logic [15:0] i_code_seg,
    input wire logic [15:0] i_imm_lo,
    input wire logic [15:0] i_imm_hi,
    input wire logic [15:0] i_rm_word,
    input wire logic [15:0] i_mem_ptr_off,
    input wire logic [15:0] i_mem_ptr_seg,
    input wire logic [15:0] i_ea_disp,
    input wire logic i_ea_sp_base,
    input wire logic [15:0] i_stack_pointer_reg,
    input wire logic [15:0] i_acc_word,
    input wire logic [15:0] i_flags,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_ea,
    output logic o_push_seg,
    output logic [15:0] o_push_seg_val,
    output logic o_push_off,
    output logic [15:0] o_push_off_val,
    output logic o_ld_offset,
    output logic [15:0] o_new_offset,
    output logic o_ld_seg,
    output logic [15:0] o_new_seg,
    output logic o_ld_acc,
    output logic [15:0] o_acc_word,
    output logic o_ld_flags,
    output logic [15:0] o_flags
);
    import csc_pkg::*;
    csc_dec_if dif ();
    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    csc_decoder u_dec (
        .i_opcode(i_opcode),
        .i_modrm(i_modrm),
        .i_byte_bus(i_byte_bus),
        .dec(dif.dec)
    );
    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    csc_state_t state_ff, nxt_state;
    csc_op_t op_ff, nxt_op;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [15:0] sp_ff, nxt_sp;
    logic [15:0] off_ff, nxt_off;
    logic [15:0] seg_ff, nxt_seg;
    logic [15:0] res_ff, nxt_res;
    logic [15:0] fl_ff, nxt_fl;
    logic take;
    logic last;
    assign take = (state_ff == CSC_ST_IDLE) && i_start && (dif.op != CSC_OP_NONE);
    assign last = (state_ff == CSC_ST_BUSY) && (cnt_ff == 6'd1);
    // Next state, counter and latched operands
    always_comb
    begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_cnt = cnt_ff;
        nxt_sp = sp_ff;
        nxt_off = off_ff;
        nxt_seg = seg_ff;
        nxt_res = res_ff;
        nxt_fl = fl_ff;
        case (state_ff)
            CSC_ST_IDLE:
            begin
                if (take)
                begin
                    nxt_state = CSC_ST_BUSY;
                    nxt_op = dif.op;
                    nxt_cnt = dif.cycles - 6'd1;
                    nxt_sp = i_stack_pointer_reg;
                    nxt_off = i_next_instr_offset;
                    nxt_seg = i_code_seg;
                    nxt_res = i_acc_word;
                    nxt_fl = i_flags;
                end
            end
            CSC_ST_BUSY:
            begin
                nxt_cnt = cnt_ff - 6'd1;
                if (last)
                begin
                    nxt_state = CSC_ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = CSC_ST_IDLE;
            end
        endcase
    end
    // Register the sequencer
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            state_ff <= CSC_ST_IDLE;
            op_ff <= CSC_OP_NONE;
            cnt_ff <= '0;
            sp_ff <= RESET_WORD;
            off_ff <= RESET_WORD;
            seg_ff <= RESET_WORD;
            res_ff <= RESET_WORD;
            fl_ff <= RESET_WORD;
        end
        else
        begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            cnt_ff <= nxt_cnt;
            sp_ff <= nxt_sp;
            off_ff <= nxt_off;
            seg_ff <= nxt_seg;
            res_ff <= nxt_res;
            fl_ff <= nxt_fl;
        end
    end
    // ------------------------------------------------------------
    // Results, applied on the final cycle
    // ------------------------------------------------------------
    logic is_call, is_far;
    assign is_call = op_ff inside {CSC_OP_NEAR_REL, CSC_OP_NEAR_REG, CSC_OP_NEAR_MEM,
                                   CSC_OP_FAR_DIR, CSC_OP_FAR_MEM};
    assign is_far = op_ff inside {CSC_OP_FAR_DIR, CSC_OP_FAR_MEM};
    assign o_busy = (state_ff == CSC_ST_BUSY);
    assign o_done = last;
    // Stack-based addressing uses the stack pointer latched at take
    assign o_ea = i_ea_sp_base ? (sp_ff + i_ea_disp) : i_ea_disp;
    assign o_push_off = last && is_call;
    assign o_push_off_val = off_ff;
    assign o_push_seg = last && is_far;
    assign o_push_seg_val = seg_ff;
    assign o_ld_seg = last && is_far;
    assign o_ld_offset = last && is_call;
    assign o_ld_acc = last && (op_ff == CSC_OP_SIGN_EXT);
    assign o_ld_flags = last && (op_ff == CSC_OP_CARRY_CLR);
    // Target, segment, accumulator and flag values
    always_comb
    begin
        o_new_offset = off_ff;
        o_new_seg = seg_ff;
        o_acc_word = res_ff;
        o_flags = fl_ff;
        case (op_ff)
            CSC_OP_NEAR_REL: o_new_offset = off_ff + i_imm_lo;
            CSC_OP_NEAR_REG, CSC_OP_NEAR_MEM: o_new_offset = i_rm_word;
            CSC_OP_FAR_DIR:
            begin
                o_new_offset = i_imm_lo;
                o_new_seg = i_imm_hi;
            end
            CSC_OP_FAR_MEM:
            begin
                o_new_offset = i_mem_ptr_off;
                o_new_seg = i_mem_ptr_seg;
            end
            CSC_OP_SIGN_EXT:
                o_acc_word = {res_ff[ACC_SIGN_BIT] ? ACC_HIGH_ONES : ACC_HIGH_ZEROS,
                              res_ff[7:0]};
            CSC_OP_CARRY_CLR: o_flags[CARRY_FLAG_BIT] = 1'b0;
            default: o_new_offset = off_ff;
        endcase
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_near_rel_len: assert property (take && dif.op == CSC_OP_NEAR_REL && !i_byte_bus
        |-> !o_done [*8] ##1 !o_done [*6] ##1 o_done) else $error("near rel call length");
    a_near_rel_b: assert property (take && dif.op == CSC_OP_NEAR_REL && i_byte_bus
        |-> ##18 o_done) else $error("near rel byte length");
    a_near_ind: assert property (take && dif.op == CSC_OP_NEAR_MEM && i_byte_bus
        |-> ##26 o_done) else $error("near mem call length");
    a_far_dir_len: assert property (take && dif.op == CSC_OP_FAR_DIR && !i_byte_bus
        |-> ##22 o_done) else $error("far direct length");
    a_far_mem_len: assert property (take && dif.op == CSC_OP_FAR_MEM && i_byte_bus
        |-> ##53 o_done) else $error("far mem length");
    a_short_len: assert property (take && dif.op inside {CSC_OP_SIGN_EXT, CSC_OP_CARRY_CLR}
        |-> ##1 o_done) else $error("short op length");
    a_sign_fill: assert property (o_ld_acc |-> o_acc_word[15:8] ==
        {8{o_acc_word[7]}}) else $error("sign fill wrong");
    a_carry_only: assert property (o_ld_flags |-> o_flags == (fl_ff & 16'hFFFE))
        else $error("carry clear touched other flags");
    a_near_seg: assert property (o_push_off && !is_far |-> !o_push_seg && !o_ld_seg)
        else $error("near call touched segment");
    a_far_push: assert property (o_ld_seg |-> o_push_seg && o_push_off &&
        o_push_seg_val == seg_ff) else $error("far call push missing");
    a_rel_target: assert property (o_ld_offset && op_ff == CSC_OP_NEAR_REL
        |-> o_new_offset == o_push_off_val + i_imm_lo) else $error("rel target");
    a_sp_held: assert property (o_busy && $past(o_busy) |-> $stable(sp_ff))
        else $error("stack base changed mid instruction");
    a_no_flags: assert property (o_done && op_ff != CSC_OP_CARRY_CLR |-> !o_ld_flags)
        else $error("flags written");
    c_near_rel: cover property (o_done && op_ff == CSC_OP_NEAR_REL);
    c_far_mem: cover property (o_done && op_ff == CSC_OP_FAR_MEM);
    c_sign_neg: cover property (o_ld_acc && o_acc_word[7]);
    c_carry_clr: cover property (o_ld_flags);
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the call / sign-extend / carry-clear execute unit
// Assumes the unit's assertions live in the design files; the bench drives all ports
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_start = 1'b0;
    logic i_byte_bus = 1'b0;
    logic [7:0] i_opcode = 8'h00;
    logic [7:0] i_modrm = 8'h00;
    logic [15:0] i_next_instr_offset = 16'h0000;
    logic [15:0] i_code_seg = 16'h0000;
    logic [15:0] i_imm_lo = 16'h0000;
    logic [15:0] i_imm_hi = 16'h0000;
    logic [15:0] i_rm_word = 16'h0000;
    logic [15:0] i_mem_ptr_off = 16'h0000;
    logic [15:0] i_mem_ptr_seg = 16'h0000;
    logic [15:0] i_ea_disp = 16'h0000;
    logic i_ea_sp_base = 1'b0;
    logic [15:0] i_stack_pointer_reg = 16'h0000;
    logic [15:0] i_acc_word = 16'h0000;
    logic [15:0] i_flags = 16'h0000;
    logic o_busy, o_done, o_push_seg, o_push_off, o_ld_offset, o_ld_seg, o_ld_acc, o_ld_flags;
    logic [15:0] o_ea, o_push_seg_val, o_push_off_val, o_new_offset, o_new_seg;
    logic [15:0] o_acc_word, o_flags;
    int seed = 22625;
    int miscompares = 0;
    int checked = 0;

    csc_exec csc_exec_inst (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_start(i_start),
        .i_byte_bus(i_byte_bus), .i_opcode(i_opcode), .i_modrm(i_modrm),
        .i_next_instr_offset(i_next_instr_offset), .i_code_seg(i_code_seg),
        .i_imm_lo(i_imm_lo), .i_imm_hi(i_imm_hi), .i_rm_word(i_rm_word),
        .i_mem_ptr_off(i_mem_ptr_off), .i_mem_ptr_seg(i_mem_ptr_seg), .i_ea_disp(i_ea_disp),
        .i_ea_sp_base(i_ea_sp_base), .i_stack_pointer_reg(i_stack_pointer_reg),
        .i_acc_word(i_acc_word), .i_flags(i_flags), .o_busy(o_busy), .o_done(o_done),
        .o_ea(o_ea), .o_push_seg(o_push_seg), .o_push_seg_val(o_push_seg_val),
        .o_push_off(o_push_off), .o_push_off_val(o_push_off_val), .o_ld_offset(o_ld_offset),
        .o_new_offset(o_new_offset), .o_ld_seg(o_ld_seg), .o_new_seg(o_new_seg),
        .o_ld_acc(o_ld_acc), .o_acc_word(o_acc_word), .o_ld_flags(o_ld_flags),
        .o_flags(o_flags)
    );

    // Core clock, 10 ns period
    always #5 i_sys_clk = ~i_sys_clk;

    // ------------------------------------------------------------
    // Compare tasks and verdict
    // ------------------------------------------------------------
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Expected instruction length: byte bus value first, word bus value second
    function automatic int exp_cyc(input int k, input logic bb);
        case (k)
            0: return bb ? 19 : 15;
            1: return bb ? 17 : 13;
            2: return bb ? 27 : 19;
            3: return bb ? 31 : 23;
            4: return bb ? 54 : 38;
            default: return 2;
        endcase
    endfunction

    // ------------------------------------------------------------
    // One instruction: k selects near rel, near reg, near mem, far dir,
    // far mem, sign extend, carry clear; corner pins edge values
    // ------------------------------------------------------------
    task automatic run_op(input int k, input logic bb, input logic corner);
        logic [15:0] nxt, cs, sp, exp_off, exp_seg;
        logic [1:0] md;
        logic call, far;
        int n, cnt;
        md = 2'(unsigned'($random(seed)) % 3);
        {i_next_instr_offset, i_code_seg} = {16'($random(seed)), 16'($random(seed))};
        {i_imm_lo, i_imm_hi, i_rm_word} = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
        {i_mem_ptr_off, i_mem_ptr_seg} = {16'($random(seed)), 16'($random(seed))};
        {i_ea_disp, i_stack_pointer_reg} = {16'($random(seed)), 16'($random(seed))};
        {i_acc_word, i_flags} = {16'($random(seed)), 16'($random(seed))};
        i_ea_sp_base = 1'($random(seed));
        if (corner)
        begin
            {i_next_instr_offset, i_imm_lo, i_acc_word, i_flags} = 64'hFFFF_0001_1280_FFFF;
            i_stack_pointer_reg = 16'hFFFE;
        end
        i_modrm = 8'($random(seed));
        case (k)
            0: i_opcode = 8'hE8;
            1: {i_opcode, i_modrm[7:3]} = {8'hFF, 2'h3, 3'h2};
            2: {i_opcode, i_modrm[7:3]} = {8'hFF, md, 3'h2};
            3: i_opcode = 8'h9A;
            4: {i_opcode, i_modrm[7:3]} = {8'hFF, md, 3'h3};
            5: i_opcode = 8'h98;
            default: i_opcode = 8'hF8;
        endcase
        i_byte_bus = bb;
        nxt = i_next_instr_offset;
        cs = i_code_seg;
        sp = i_stack_pointer_reg;
        n = exp_cyc(k, bb);
        call = (k < 5);
        far = (k == 3 || k == 4);
        exp_off = (k == 0) ? nxt + i_imm_lo : (k == 3) ? i_imm_lo : (k == 4) ? i_mem_ptr_off : i_rm_word;
        exp_seg = (k == 3) ? i_imm_hi : i_mem_ptr_seg;
        i_start = 1'b1;
        @(posedge i_sys_clk);
        #1;
        i_start = 1'b0;
        i_stack_pointer_reg = ~sp;
        chk1("busy", 1'b1, o_busy);
        if (k == 2 || k == 4)
            chk16("ea", i_ea_sp_base ? sp + i_ea_disp : i_ea_disp, o_ea);
        cnt = 1;
        while (o_done !== 1'b1 && cnt < 100)
        begin
            @(posedge i_sys_clk);
            #1;
            cnt++;
        end
        chk16("cycles", 16'(n - 1), 16'(cnt));
        chk1("push_off", call, o_push_off);
        if (call)
            chk16("push_off_val", nxt, o_push_off_val);
        chk1("push_seg", far, o_push_seg);
        if (far)
            chk16("push_seg_val", cs, o_push_seg_val);
        chk1("ld_offset", call, o_ld_offset);
        if (call)
            chk16("new_offset", exp_off, o_new_offset);
        chk1("ld_seg", far, o_ld_seg);
        if (far)
            chk16("new_seg", exp_seg, o_new_seg);
        chk1("ld_acc", k == 5, o_ld_acc);
        if (k == 5)
            chk16("acc_word", {i_acc_word[7] ? 8'hFF : 8'h00, i_acc_word[7:0]}, o_acc_word);
        chk1("ld_flags", k == 6, o_ld_flags);
        if (k == 6)
            chk16("flags", i_flags & 16'hFFFE, o_flags);
        @(posedge i_sys_clk);
        #1;
        chk1("idle_after", 1'b0, o_busy);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge i_sys_clk);
        #1;
        chk1("busy_in_reset", 1'b0, o_busy);
        i_sys_rst = 1'b0;
        for (int b = 0; b < 2; b++)
            for (int k = 0; k < 7; k++)
                run_op(k, 1'(b), 1'b1);
        // Unrecognised forms must not start anything
        for (int i = 0; i < 3; i++)
        begin
            i_opcode = (i == 0) ? 8'h90 : 8'hFF;
            i_modrm = (i == 1) ? 8'hD9 : 8'h05;
            i_start = 1'b1;
            @(posedge i_sys_clk);
            #1;
            i_start = 1'b0;
            chk1("bad_busy", 1'b0, o_busy);
            chk1("bad_done", 1'b0, o_done);
        end
        for (int r = 0; r < 120; r++)
            run_op(int'(unsigned'($random(seed)) % 7), 1'($random(seed)), 1'b0);
        tally_and_finish();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule
